/* File: rtl/hps_top.sv */
// host port mode straps, ready and interrupt pins
// assumes one clock domain; core_ready and core_irq come from logic on ref_clk;
// output enables are active low and the testbench resolves the pin levels
`timescale 1ns/1ps

module hps_top
  import hps_pkg::*;
(
  // clock, reset, enable
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  input  wire logic  clk_en,
  // pins from the board and host
  input  wire logic  chip_reset_n,
  input  wire logic  port_select_strap,
  input  wire logic  wide_mode_strap,
  input  wire logic  outputs_off_n,
  input  wire logic  host_strobe_n,
  input  wire logic  register_select_0,
  input  wire logic  register_select_1,
  input  wire logic  byte_identify,
  // core side
  input  wire logic  core_ready,
  input  wire logic  core_irq,
  // pins to the host
  output logic       host_ready_out,
  output logic       host_ready_oe_n,
  output logic       host_interrupt_out,
  output logic       host_interrupt_oe_n,
  // mode status
  output logic       port_enabled,
  output logic       wide_mode,
  output logic       pullup_en,
  output logic       holder_en,
  // access toward the core
  output logic       access_valid,
  output hps_access_s access
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_s;

  assign pins_async = {byte_identify, register_select_1, register_select_0, host_strobe_n,
                       outputs_off_n, wide_mode_strap, port_select_strap, chip_reset_n};

  hps_sync u_sync (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .pin_async  (pins_async),
    .pin_stable (pins_s)
  );

  wire chip_run_s  = pins_s[PIN_CHIP_RST_N];
  wire port_strap_s = pins_s[PIN_PORT_SEL];
  wire wide_s      = pins_s[PIN_WIDE];
  wire off_n_s     = pins_s[PIN_OFF_N];
  wire strobe_n_s  = pins_s[PIN_STROBE_N];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic chip_prev_q;
  logic port_sel_q;
  logic port_sel_d;
  logic strobe_prev_q;

  wire chip_rise   = chip_run_s && !chip_prev_q;
  wire strobe_fall = !strobe_n_s && strobe_prev_q;

  // the select strap is taken only at the release of chip reset; later changes are ignored
  assign port_sel_d = chip_rise ? port_strap_s : port_sel_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chip_prev_q   <= 1'b0;
      port_sel_q    <= SEL_RST;
      strobe_prev_q <= 1'b1;
    end else if (clk_en) begin
      chip_prev_q   <= chip_run_s;
      port_sel_q    <= port_sel_d;
      strobe_prev_q <= strobe_n_s;
    end
  end

  // ----------------------------------------------------------------
  // host-side transfer tracking
  // ----------------------------------------------------------------
  hps_state_e  state_q;
  hps_state_e  state_d;
  hps_access_s acc_d;
  logic        live;

  // deselected port or core in reset: strobes are not seen at all
  assign live = port_sel_q && chip_run_s;

  // register select and byte identify only mean something in narrow mode
  assign acc_d = wide_s ? hps_access_s'{reg_sel: RSEL_NONE, byte_sel: 1'b0, wide: 1'b1}
                        : hps_access_s'{reg_sel: {pins_s[PIN_RSEL_HI], pins_s[PIN_RSEL_LO]},
                                        byte_sel: pins_s[PIN_BYTE_ID], wide: 1'b0};

  always_comb begin
    state_d = state_q;
    if (!live) begin
      state_d = HPS_IDLE;
    end else begin
      case (state_q)
        HPS_IDLE: begin
          if (strobe_fall) begin
            state_d = HPS_BUSY;
          end
        end
        HPS_BUSY: begin
          if (core_ready) begin
            state_d = HPS_RELEASE;
          end
        end
        HPS_RELEASE: begin
          // wait for the host to lift its strobe so one strobe is one transfer
          if (strobe_n_s) begin
            state_d = HPS_IDLE;
          end
        end
        default: state_d = HPS_IDLE;
      endcase
    end
  end

  wire start_xfer = live && (state_q == HPS_IDLE) && strobe_fall;

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // a strap capture that deselects the port must also withhold ready in the same edge
  wire ready_d = live && port_sel_d && core_ready && (state_d == HPS_IDLE);
  // interrupt is active low; held inactive in reset, in wide mode and when deselected
  wire irq_d   = (!chip_run_s || wide_s || !port_sel_q) ? IRQ_IDLE : !core_irq;
  wire oe_n_d  = !off_n_s;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q             <= HPS_IDLE;
      host_ready_out      <= RDY_RST;
      host_ready_oe_n     <= OE_N_RST;
      host_interrupt_out  <= IRQ_RST;
      host_interrupt_oe_n <= OE_N_RST;
      port_enabled        <= SEL_RST;
      wide_mode           <= 1'b0;
      pullup_en           <= !SEL_RST;
      holder_en           <= !SEL_RST;
      access_valid        <= 1'b0;
      access              <= ACCESS_NONE;
    end else if (clk_en) begin
      state_q             <= state_d;
      host_ready_out      <= ready_d;
      host_ready_oe_n     <= oe_n_d;
      host_interrupt_out  <= irq_d;
      host_interrupt_oe_n <= oe_n_d;
      port_enabled        <= port_sel_d;
      wide_mode           <= wide_s;
      pullup_en           <= !port_sel_d;
      holder_en           <= !port_sel_d;
      access_valid        <= start_xfer;
      if (start_xfer) begin
        access <= acc_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_needs_port: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_ready_out |-> port_sel_q && (state_q == HPS_IDLE))
    else $error("ready shown while port deselected or busy");

  a_ready_drops_strobe: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && start_xfer |=> !host_ready_out && (state_q == HPS_BUSY))
    else $error("ready not withdrawn after strobe");

  a_ready_off_hiz: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !off_n_s |=> host_ready_oe_n)
    else $error("ready pin driven while outputs off");

  a_irq_reset_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !chip_run_s |=> host_interrupt_out)
    else $error("interrupt not high during chip reset");

  a_irq_off_hiz: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !off_n_s |=> host_interrupt_oe_n && host_ready_oe_n == host_interrupt_oe_n)
    else $error("interrupt pin driven while outputs off");

  a_irq_wide_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && wide_s |=> host_interrupt_out && wide_mode)
    else $error("interrupt active in wide mode");

  a_strap_sample: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && chip_rise |=> port_enabled == $past(port_strap_s) && pullup_en == !port_enabled)
    else $error("select strap not captured at reset release");

  a_strap_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !chip_rise |=> port_sel_q == $past(port_sel_q))
    else $error("select strap changed outside reset release");

  a_desel_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !port_sel_q |=> !access_valid && (state_q == HPS_IDLE) && !host_ready_out)
    else $error("deselected port reacted to host");

  a_wide_fields: assert property (@(posedge ref_clk) disable iff (sys_rst)
    access_valid && access.wide |-> access.reg_sel == RSEL_NONE && !access.byte_sel)
    else $error("narrow-mode fields leaked into wide access");

endmodule

/* File: rtl/hps_pkg.sv */
// host port mode straps and status pins: shared constants and types
// assumes a single 200 mhz clock domain; all pin inputs are synchronised in hps_sync
//
// Functional notes
// - The device drives host_ready_out to tell the host whether the next transfer can be accepted.
// - While the active-low outputs-off input is low, host_ready_out is released to high impedance.
// - While the processor is held in chip reset, host_interrupt_out is driven high (inactive).
// - While the active-low outputs-off input is low, host_interrupt_out is placed in high impedance.
// - With the wide-mode strap high the interrupt output is unused and stays at its inactive level.
// - The port is enabled only when the select strap is high; otherwise pull-ups and bus holders are enabled.
// - The select strap is sampled when chip_reset_n rises and is ignored until chip reset is asserted again.
// - The 16-bit wide mode is enabled only while the wide-mode strap is high.
package hps_pkg;

  // ----------------------------------------------------------------
  // synchroniser layout
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W     = 8;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned PIN_CHIP_RST_N = 0;
  localparam int unsigned PIN_PORT_SEL   = 1;
  localparam int unsigned PIN_WIDE       = 2;
  localparam int unsigned PIN_OFF_N      = 3;
  localparam int unsigned PIN_STROBE_N   = 4;
  localparam int unsigned PIN_RSEL_LO    = 5;
  localparam int unsigned PIN_RSEL_HI    = 6;
  localparam int unsigned PIN_BYTE_ID    = 7;

  // pins idle at: reset asserted, straps low (pull-downs), outputs on, strobe high
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 8'h98;

  // ----------------------------------------------------------------
  // reset values of the outputs
  // ----------------------------------------------------------------
  localparam logic RDY_RST   = 1'b0;
  localparam logic OE_N_RST  = 1'b1;
  localparam logic IRQ_RST   = 1'b1;
  localparam logic IRQ_IDLE  = 1'b1;
  localparam logic SEL_RST   = 1'b0;
  localparam logic [1:0] RSEL_NONE = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HPS_IDLE,
    HPS_BUSY,
    HPS_RELEASE
  } hps_state_e;

  typedef struct packed {
    logic [1:0] reg_sel;
    logic       byte_sel;
    logic       wide;
  } hps_access_s;

  localparam hps_access_s ACCESS_NONE = '{reg_sel: RSEL_NONE, byte_sel: 1'b0, wide: 1'b0};

endpackage

/* File: rtl/hps_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to ref_clk; output changes only when stages two and three agree
`timescale 1ns/1ps

module hps_sync
  import hps_pkg::*;
(
  // clock and control
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // pins in, filtered levels out
  input  wire logic [SYNC_W-1:0] pin_async,
  output logic      [SYNC_W-1:0] pin_stable
);

  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] stable_q;

  // first stage feeds only the second; filter looks at stages two and three
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          s1_q[g]     <= SYNC_RST_VAL[g];
          s2_q[g]     <= SYNC_RST_VAL[g];
          s3_q[g]     <= SYNC_RST_VAL[g];
          stable_q[g] <= SYNC_RST_VAL[g];
        end else if (clk_en) begin
          s1_q[g] <= pin_async[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            stable_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  assign pin_stable = stable_q;

endmodule

/* File: dv/hps_host_model.sv */
// host side of the parallel port: strobes one transfer per go request
// assumes go is held by the bench until the transfer is seen, then lowered
`timescale 1ns/1ps

module hps_host_model (
  // clock and request from the bench
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [1:0] rsel,
  input  wire logic       bid,
  // host pins
  output logic            host_strobe_n,
  output logic            register_select_0,
  output logic            register_select_1,
  output logic            byte_identify
);
  logic [3:0] cnt_q;

  initial begin
    cnt_q             = 4'h0;
    host_strobe_n     = 1'b1;
    register_select_0 = 1'b0;
    register_select_1 = 1'b0;
    byte_identify     = 1'b0;
  end

  // strobe held low long enough to pass the pin filter
  always @(negedge ref_clk) begin
    if (go && cnt_q == 4'h0) begin
      host_strobe_n     <= 1'b0;
      register_select_0 <= rsel[0];
      register_select_1 <= rsel[1];
      byte_identify     <= bid;
      cnt_q             <= 4'hc;
    end else if (cnt_q > 4'h2) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (cnt_q == 4'h2) begin
      host_strobe_n <= 1'b1;
      cnt_q         <= 4'h1;
    end else if (cnt_q == 4'h1) begin
      // selects no longer held: show a changed level, not a stale one
      register_select_0 <= ~register_select_0;
      register_select_1 <= ~register_select_1;
      byte_identify     <= ~byte_identify;
      if (!go) cnt_q <= 4'h0;
    end
  end
endmodule

/* File: dv/tb.sv */
// self-checking bench for the host port straps, ready and interrupt pins
// assumes hps_top and the host model; inputs change on the falling edge
`timescale 1ns/1ps

module tb
  import hps_pkg::*;
;
  logic        ref_clk, sys_rst, chip_reset_n, port_select_strap, wide_mode_strap;
  logic        outputs_off_n, core_ready, core_irq, go, h_bid, clk_en;
  logic [1:0]  h_rsel;
  wire  logic  strobe_n, rs0, rs1, bid_pin, rdy_out, rdy_oe_n, int_out, int_oe_n;
  wire  logic  port_enabled, wide_mode, pullup_en, holder_en, access_valid;
  hps_access_s access;
  int          fail_count, total_checks;
  // pins have no pull: released means high impedance
  wire  logic  ready_pin = rdy_oe_n ? 1'bz : rdy_out;
  wire  logic  int_pin   = int_oe_n ? 1'bz : int_out;

  hps_top u_hps_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .chip_reset_n(chip_reset_n),
    .port_select_strap(port_select_strap), .wide_mode_strap(wide_mode_strap), .outputs_off_n(outputs_off_n),
    .host_strobe_n(strobe_n), .register_select_0(rs0), .register_select_1(rs1), .byte_identify(bid_pin),
    .core_ready(core_ready), .core_irq(core_irq), .host_ready_out(rdy_out), .host_ready_oe_n(rdy_oe_n),
    .host_interrupt_out(int_out), .host_interrupt_oe_n(int_oe_n), .port_enabled(port_enabled),
    .wide_mode(wide_mode), .pullup_en(pullup_en), .holder_en(holder_en), .access_valid(access_valid),
    .access(access));
  hps_host_model u_hps_host_model (.ref_clk(ref_clk), .go(go), .rsel(h_rsel), .bid(h_bid),
    .host_strobe_n(strobe_n), .register_select_0(rs0), .register_select_1(rs1), .byte_identify(bid_pin));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_acc(input hps_access_s exp);
    total_checks++;
    if (access !== exp) begin
      fail_count++;
      $display("unexpected access expected %h seen %h", exp, access);
    end
  endtask

  task automatic pause(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one host transfer; a missing expected transfer ends the run
  task automatic run_access(input logic [1:0] rs, input logic b, input logic exp_v, input hps_access_s exp);
    logic found;
    found = 1'b0;
    h_rsel = rs;
    h_bid  = b;
    go     = 1'b1;
    for (int i = 0; i < 30 && !found; i++) begin
      @(posedge ref_clk);
      #1;
      found = (access_valid === 1'b1);
    end
    check_bit("access_valid", exp_v, found);
    if (found) begin
      check_acc(exp);
      check_bit("ready_busy", 1'b0, ready_pin);
    end
    if (exp_v && !found) report_and_stop();
    @(negedge ref_clk);
    go = 1'b0;
    pause(20);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_deselect();
    // core says ready: the pin must still stay low in chip reset and while deselected
    core_ready = 1'b1;
    pause(4);
    check_bit("int_in_reset", 1'b1, int_pin);
    check_bit("ready_in_reset", 1'b0, ready_pin);
    chip_reset_n = 1'b1;
    pause(8);
    check_bit("port_enabled", 1'b0, port_enabled);
    check_bit("pullup_en", 1'b1, pullup_en);
    check_bit("holder_en", 1'b1, holder_en);
    run_access(2'h1, 1'b1, 1'b0, ACCESS_NONE);
    check_bit("ready_desel", 1'b0, ready_pin);
  endtask

  task automatic t_strap_capture();
    chip_reset_n = 1'b0;
    pause(8);
    port_select_strap = 1'b1;
    chip_reset_n = 1'b1;
    pause(8);
    check_bit("port_enabled", 1'b1, port_enabled);
    check_bit("pullup_en", 1'b0, pullup_en);
    check_bit("holder_en", 1'b0, holder_en);
    port_select_strap = 1'b0;
    pause(8);
    check_bit("port_held", 1'b1, port_enabled);
  endtask

  task automatic t_narrow_access();
    core_ready = 1'b1;
    pause(8);
    check_bit("ready_idle", 1'b1, ready_pin);
    for (int r = 1; r < 4; r++) begin
      run_access(r[1:0], r[0], 1'b1, '{r[1:0], r[0], 1'b0});
      check_bit("ready_again", 1'b1, ready_pin);
    end
  endtask

  task automatic t_irq_wide();
    core_irq = 1'b1;
    pause(8);
    check_bit("int_active", 1'b0, int_pin);
    wide_mode_strap = 1'b1;
    pause(8);
    check_bit("wide_mode", 1'b1, wide_mode);
    check_bit("int_wide", 1'b1, int_pin);
    run_access(2'h3, 1'b1, 1'b1, '{2'h0, 1'b0, 1'b1});
    wide_mode_strap = 1'b0;
    pause(8);
    check_bit("wide_off", 1'b0, wide_mode);
    check_bit("int_narrow", 1'b0, int_pin);
  endtask

  task automatic t_outputs_off();
    // with the clock enable low the pin drivers must not follow the outputs-off pin
    clk_en = 1'b0;
    outputs_off_n = 1'b0;
    pause(8);
    check_bit("oe_frozen", 1'b0, rdy_oe_n);
    clk_en = 1'b1;
    pause(8);
    check_bit("ready_off", 1'bz, ready_pin);
    check_bit("int_off", 1'bz, int_pin);
    outputs_off_n = 1'b1;
    pause(8);
    check_bit("int_on", 1'b0, int_pin);
    chip_reset_n = 1'b0;
    pause(8);
    check_bit("int_chip_reset", 1'b1, int_pin);
  endtask

  initial begin
    fail_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    chip_reset_n = 1'b0;
    port_select_strap = 1'b0;
    wide_mode_strap = 1'b0;
    outputs_off_n = 1'b1;
    core_ready = 1'b0;
    core_irq = 1'b0;
    go = 1'b0;
    h_rsel = 2'h0;
    h_bid = 1'b0;
    pause(8);
    sys_rst = 1'b0;
    pause(8);
    t_reset_and_deselect();
    t_strap_capture();
    t_narrow_access();
    t_irq_wide();
    t_outputs_off();
    report_and_stop();
  end
endmodule
